// [dcs_device.sv]
`timescale 1ns/1ns
// What this block does
// [R1] 33 cells: data bits plus break cell
// [R2] status bit 4 flags compressed-state entry
// [R3] debugger may duplicate 16-bit halves
// [R4] store multiple drives registers onto bus
// [R5] any mode change allowed in debug
// [R6] debugger restores entry mode before exit
// [R7] 33 test clocks between core steps
// [R8] debugger scans only permitted instruction classes
// [R9] system access uses system clock enable
// [R10] cell 33 high selects next system speed
// [R11] debugger issues resume after system instruction
// [R12] resume runs pending op, re-enters debug
// [R13] completion raises acknowledge, back to debug
// [R14] transfer type driven low requesting bus
// [R15] tolerate unbounded bus grant stall
// [R16] completion needs transfer bits and acknowledge
// [R17] status shows transfer bits and acknowledge
// [R18] cell 33 high only on memory ops
// [R19] cell 33 set after system access
// [R20] first capture of cell 33 shows cause
// [R21] breakpoint reads low, watchpoint reads high
// [R22] order: data 0..31 then break cell
// [R23] chain 1 selected before shifting
// [R24] capture, shift, update per test clock
module dcs_device
  import dcs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  dcs_if.device                  dbg,
  input  wire logic              debug_entry,
  input  wire logic              entry_watchpoint,
  input  wire logic              entry_compressed,
  input  wire logic [DATA_W-1:0] core_data_out,
  input  wire logic              bus_grant,
  output logic [DATA_W-1:0]      core_instr,
  output logic                   core_step,
  output logic                   system_clock_enable,
  output logic                   debug_clock_enable,
  output logic                   debug_acknowledge,
  output logic [1:0]             trans_type,
  output logic [MODE_W-1:0]      core_mode,
  output logic                   test_data_out_q
);
  typedef enum logic [1:0] {DCS_DEBUG, DCS_SYNC, DCS_WAIT, DCS_RUN}
    dcs_state_e;

  // two-flop sync on every pin from the debugger
  logic [9:0] s1_reg;
  logic [9:0] s2_reg;
  logic [3:0] sel1_reg;
  logic [3:0] sel2_reg;
  logic       tck_prev_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      sel1_reg <= '0;
      sel2_reg <= '0;
    end else begin
      s1_reg <= {dbg.tck, dbg.capture, dbg.shift, dbg.update,
                 dbg.select_chain, dbg.resume, dbg.step, dbg.status_rd,
                 dbg.mode_wr, dbg.test_data_input};
      s2_reg   <= s1_reg;
      sel1_reg <= dbg.chain_sel;
      sel2_reg <= sel1_reg;
    end
  end
  always_ff @(posedge clk) begin
    tck_prev_reg <= reset ? 1'b0 : s2_reg[9];
  end
  logic tck_rise;
  assign tck_rise = s2_reg[9] && !tck_prev_reg;
  logic cap_i, shf_i, upd_i, selc_i, res_i, stp_i, mode_i, tdi_i;
  assign cap_i  = s2_reg[8];
  assign shf_i  = s2_reg[7];
  assign upd_i  = s2_reg[6];
  assign selc_i = s2_reg[5];
  assign res_i  = s2_reg[4];
  assign stp_i  = s2_reg[3];
  assign mode_i = s2_reg[1];
  assign tdi_i  = s2_reg[0];

  logic [SEL_W-1:0]     chain_reg;
  logic [CHAIN_LEN-1:0] sr_reg;
  logic [CHAIN_LEN-1:0] par_reg;
  logic                 first_cap_reg;
  logic                 cause_reg;
  logic                 compressed_reg;
  logic [5:0]           shift_cnt_reg;
  dcs_state_e           state_reg;
  logic                 chain_on;
  assign chain_on = (chain_reg == SEL_W'(DEBUG_CHAIN_ID)); // [R23]

  always_ff @(posedge clk) begin
    if (reset) begin
      chain_reg <= '0;
    end else if (tck_rise && selc_i) begin
      chain_reg <= sel2_reg;
    end
  end

  // entry cause held until the first capture reads it
  always_ff @(posedge clk) begin
    if (reset) begin
      first_cap_reg  <= 1'b0;
      cause_reg      <= 1'b0;
      compressed_reg <= 1'b0;
    end else if (debug_entry && state_reg == DCS_DEBUG) begin
      first_cap_reg  <= 1'b1;
      cause_reg      <= entry_watchpoint; // [R21]
      compressed_reg <= entry_compressed; // [R2]
    end else if (state_reg == DCS_RUN) begin
      // excursion over: the core is back in debug by itself
      first_cap_reg <= 1'b1;
      cause_reg     <= 1'b1; // [R19]
    end else if (tck_rise && cap_i && chain_on) begin
      first_cap_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sr_reg        <= '0;
      shift_cnt_reg <= '0;
    end else if (tck_rise && chain_on && cap_i) begin
      sr_reg[DATA_W-1:0] <= core_data_out; // [R4] [R24]
      sr_reg[SPEED_BIT]  <= first_cap_reg ? cause_reg // [R20]
                                          : par_reg[SPEED_BIT];
      shift_cnt_reg      <= '0;
    end else if (tck_rise && chain_on && shf_i) begin
      // bit 0 leaves first: data 0..31 then the break cell
      sr_reg <= {tdi_i, sr_reg[CHAIN_LEN-1:1]}; // [R1] [R22] [R24]
      if (shift_cnt_reg != 6'(CHAIN_LEN)) begin
        shift_cnt_reg <= shift_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      par_reg <= '0;
    end else if (tck_rise && chain_on && upd_i) begin
      par_reg <= sr_reg; // [R24]
    end
  end

  always_ff @(posedge clk) begin
    test_data_out_q <= reset ? 1'b0 : (chain_on && sr_reg[0]);
  end
  assign dbg.test_data_output = test_data_out_q;

  // only after a full word has passed may the core step
  logic step_ok;
  assign step_ok = tck_rise && stp_i && chain_on &&
                   shift_cnt_reg == 6'(CHAIN_LEN); // [R7]

  logic speed_pending_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      speed_pending_reg <= 1'b0;
    end else if (step_ok && state_reg == DCS_DEBUG) begin
      // stays armed through the step that loads the system speed op
      speed_pending_reg <= speed_pending_reg || par_reg[SPEED_BIT]; // [R10]
    end else if (state_reg == DCS_RUN) begin
      speed_pending_reg <= 1'b0;
    end
  end

  // state machine for the system speed excursion
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= DCS_DEBUG;
    end else begin
      case (state_reg)
        DCS_DEBUG: if (tck_rise && res_i && speed_pending_reg) begin
          state_reg <= DCS_SYNC; // [R12]
        end
        DCS_SYNC: state_reg <= DCS_WAIT; // [R9]
        DCS_WAIT: if (bus_grant) begin
          state_reg <= DCS_RUN; // [R15]
        end
        DCS_RUN: state_reg <= DCS_DEBUG; // [R13]
        default: state_reg <= DCS_DEBUG;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      system_clock_enable <= 1'b0;
      debug_clock_enable  <= 1'b1;
      debug_acknowledge   <= 1'b1;
      trans_type          <= TRANS_DONE;
      core_step           <= 1'b0;
    end else begin
      // mode flag: held through a grant stall, the core only waits
      system_clock_enable <= (state_reg == DCS_SYNC) ||
                             (state_reg == DCS_WAIT); // [R9] [R15]
      debug_clock_enable  <= (state_reg == DCS_DEBUG) ||
                             (state_reg == DCS_RUN); // [R13]
      debug_acknowledge   <= (state_reg == DCS_DEBUG) ||
                             (state_reg == DCS_RUN); // [R13]
      trans_type <= (state_reg == DCS_SYNC || state_reg == DCS_WAIT)
                    ? TRANS_IDLE : TRANS_DONE; // [R14] [R15]
      core_step  <= step_ok && state_reg == DCS_DEBUG;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      core_instr <= '0;
    end else if (step_ok) begin
      core_instr <= par_reg[DATA_W-1:0];
    end
  end

  // mode change is free in debug; privilege is not checked
  always_ff @(posedge clk) begin
    if (reset) begin
      core_mode <= '0;
    end else if (tck_rise && mode_i && state_reg == DCS_DEBUG) begin
      core_mode <= par_reg[MODE_W-1:0]; // [R5]
    end
  end

  logic [STAT_W-1:0] status_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      // shows the reset levels of its sources, never a false bus request
      status_reg              <= '0;
      status_reg[ST_ACK]      <= 1'b1;
      status_reg[ST_TRANS_LO] <= TRANS_DONE[0];
      status_reg[ST_TRANS_HI] <= TRANS_DONE[1];
    end else begin
      status_reg <= '0;
      status_reg[ST_ACK]        <= debug_acknowledge; // [R17]
      status_reg[ST_TRANS_LO]   <= trans_type[0]; // [R17]
      status_reg[ST_TRANS_HI]   <= trans_type[1]; // [R17]
      status_reg[ST_COMPRESSED] <= compressed_reg; // [R2]
      status_reg[ST_SYS_MODE]   <= system_clock_enable;
    end
  end
  assign dbg.status = status_reg;
endmodule

// [dcs_pkg.sv]
package dcs_pkg;
  localparam int CHAIN_LEN      = 33;
  localparam int DATA_W         = 32;
  localparam int SPEED_BIT      = 32;
  localparam int DEBUG_CHAIN_ID = 1;
  localparam int SEL_W          = 4;
  localparam int TCK_DIV        = 4;
  localparam int STAT_W         = 8;
  localparam int ST_ACK         = 0;
  localparam int ST_TRANS_LO    = 2;
  localparam int ST_TRANS_HI    = 3;
  localparam int ST_COMPRESSED  = 4;
  localparam int ST_SYS_MODE    = 5;
  localparam int MODE_W         = 5;
  localparam logic [1:0] TRANS_IDLE = 2'h0;
  localparam logic [1:0] TRANS_DONE = 2'h3;
  localparam logic [3:0] OP_NONE    = 4'h0;
  localparam logic [3:0] OP_CAPTURE = 4'h1;
  localparam logic [3:0] OP_SHIFT   = 4'h2;
  localparam logic [3:0] OP_UPDATE  = 4'h3;
  localparam logic [3:0] OP_SELECT  = 4'h4;
  localparam logic [3:0] OP_RESUME  = 4'h5;
  localparam logic [3:0] OP_STEP    = 4'h6;
  localparam logic [3:0] OP_STATUS  = 4'h7;
  localparam logic [3:0] OP_MODE    = 4'h8;
  localparam logic [7:0] ADDR_CMD    = 8'h00;
  localparam logic [7:0] ADDR_WDATA  = 8'h04;
  localparam logic [7:0] ADDR_RDATA  = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_SPEED  = 8'h10;
endpackage

// [dcs_if.sv]
`timescale 1ns/1ns
interface dcs_if;
  logic       tck;
  logic       capture;
  logic       shift;
  logic       update;
  logic       select_chain;
  logic [3:0] chain_sel;
  logic       resume;
  logic       step;
  logic       status_rd;
  logic       mode_wr;
  logic       test_data_input;
  logic       test_data_output;
  logic [7:0] status;
  modport device (input tck, capture, shift, update, select_chain,
                  chain_sel, resume, step, status_rd, mode_wr,
                  test_data_input, output test_data_output, status);
  modport debugger (output tck, capture, shift, update, select_chain,
                    chain_sel, resume, step, status_rd, mode_wr,
                    test_data_input, input test_data_output, status);
endinterface

// [dcs_clk_div.sv]
`timescale 1ns/1ns
module dcs_clk_div #(
  parameter int DIV = 4
) (
  input  wire logic clk,
  input  wire logic reset,
  output logic      tick
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt_reg;
  initial begin
    if (DIV < 2) $error("divider must be at least 2");
  end
  always_ff @(posedge clk) begin
    if (reset || cnt_reg == CW'(DIV - 1)) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    tick <= !reset && (cnt_reg == CW'(DIV - 1));
  end
endmodule

// [dcs_debugger.sv]
`timescale 1ns/1ns
module dcs_debugger
  import dcs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  dcs_if.debugger          dbg,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  output logic             busy
);
  logic [CHAIN_LEN-1:0] out_reg;
  logic [CHAIN_LEN-1:0] in_reg;
  logic [3:0]           op_reg;
  logic                 speed_reg;
  logic [5:0]           cnt_reg;
  logic                 phase_reg;
  logic [7:0]           stat_reg;
  logic                 tck_reg;
  logic [9:0]           ctl_reg;
  logic [3:0]           sel_reg;
  logic                 tdo1_reg;
  logic                 tdo2_reg;
  logic [7:0]           st1_reg;
  logic [7:0]           st2_reg;
  logic                 tick;
  dcs_clk_div #(.DIV(TCK_DIV)) u_div (
    .clk   (clk),
    .reset (reset),
    .tick  (tick)
  );
  always_ff @(posedge clk) begin
    if (reset) begin
      tdo1_reg <= 1'b0;
      tdo2_reg <= 1'b0;
      st1_reg  <= '0;
      st2_reg  <= '0;
    end else begin
      tdo1_reg <= dbg.test_data_output;
      tdo2_reg <= tdo1_reg;
      st1_reg  <= dbg.status;
      st2_reg  <= st1_reg;
    end
  end
  // cell 33 only honoured for memory ops, software's duty
  always_ff @(posedge clk) begin
    if (reset) begin
      out_reg   <= '0;
      speed_reg <= 1'b0;
      sel_reg   <= '0;
    end else if (wr && addr == ADDR_WDATA) begin
      out_reg[DATA_W-1:0] <= wdata; // [R3] [R8]
      sel_reg             <= wdata[3:0]; // [R23]
    end else if (wr && addr == ADDR_SPEED) begin
      speed_reg <= wdata[0]; // [R10] [R18]
    end
  end
  // a word takes 33 test clocks, then one for the op itself
  always_ff @(posedge clk) begin
    if (reset) begin
      op_reg    <= OP_NONE;
      cnt_reg   <= '0;
      phase_reg <= 1'b0;
      tck_reg   <= 1'b0;
      ctl_reg   <= '0;
      in_reg    <= '0;
      stat_reg  <= '0;
    end else if (wr && addr == ADDR_CMD && op_reg == OP_NONE) begin
      op_reg    <= wdata[3:0];
      cnt_reg   <= '0;
      phase_reg <= 1'b0;
    end else if (tick && op_reg != OP_NONE) begin
      phase_reg <= !phase_reg;
      tck_reg   <= !phase_reg;
      if (!phase_reg) begin
        ctl_reg <= {1'b1,
                    op_reg == OP_CAPTURE, op_reg == OP_SHIFT,
                    op_reg == OP_UPDATE, op_reg == OP_SELECT,
                    op_reg == OP_RESUME, op_reg == OP_STEP,
                    op_reg == OP_STATUS, op_reg == OP_MODE,
                    op_reg == OP_SHIFT ? in_reg[0] : 1'b0};
        if (op_reg == OP_SHIFT && cnt_reg == 6'h00) begin
          in_reg <= {speed_reg, out_reg[DATA_W-1:0]};
          ctl_reg[0] <= out_reg[0];
        end
      end else begin
        if (op_reg == OP_SHIFT) begin
          in_reg <= {tdo2_reg, in_reg[CHAIN_LEN-1:1]}; // [R7]
        end
        if (op_reg == OP_STATUS) begin
          stat_reg <= st2_reg; // [R16]
        end
        if (op_reg != OP_SHIFT || cnt_reg == 6'(CHAIN_LEN - 1)) begin
          op_reg <= OP_NONE;
          ctl_reg <= '0;
        end
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
  assign dbg.tck             = tck_reg;
  assign dbg.capture         = ctl_reg[8];
  assign dbg.shift           = ctl_reg[7];
  assign dbg.update          = ctl_reg[6];
  assign dbg.select_chain    = ctl_reg[5];
  assign dbg.resume          = ctl_reg[4]; // [R11]
  assign dbg.step            = ctl_reg[3];
  assign dbg.status_rd       = ctl_reg[2];
  assign dbg.mode_wr         = ctl_reg[1]; // [R6]
  assign dbg.test_data_input = ctl_reg[0];
  assign dbg.chain_sel       = sel_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= '0;
      busy  <= 1'b0;
    end else begin
      busy <= op_reg != OP_NONE;
      case (addr)
        ADDR_RDATA:  rdata <= rd ? in_reg[DATA_W-1:0] : '0;
        // done when both transfer bits and acknowledge are high
        ADDR_STATUS: rdata <= rd ? {22'h0, in_reg[SPEED_BIT],
                                    op_reg != OP_NONE, stat_reg} : '0;
        default:     rdata <= '0;
      endcase
    end
  end
endmodule

// [dcs_chk_asserts.sv]
`timescale 1ns/1ns
module dcs_chk_asserts
  import dcs_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       tck,
  input wire logic       capture,
  input wire logic       shift,
  input wire logic       update,
  input wire logic       select_chain,
  input wire logic [3:0] chain_sel,
  input wire logic       resume,
  input wire logic       step,
  input wire logic       status_rd,
  input wire logic       mode_wr,
  input wire logic       test_data_input,
  input wire logic       test_data_output,
  input wire logic [7:0] status
);
  logic       tck_d_reg;
  logic [5:0] rise_cnt_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  always_ff @(posedge clk) begin
    tck_d_reg <= tck;
  end
  // counts tck rises within one shift burst
  always_ff @(posedge clk) begin
    if (reset || !shift)
      rise_cnt_reg <= 6'h00;
    else if (tck && !tck_d_reg)
      rise_cnt_reg <= rise_cnt_reg + 6'h01;
  end
  sequence tck_hold;
    $stable(tck) [*3];
  endsequence
  sequence cap_stand;
    capture [*4];
  endsequence
  reset_val_a: assert property ($fell(reset) |-> status == 8'h0D)
    else $error("status wrong after reset");
  tck_period_a: assert property ($changed(tck) |=> tck_hold)
    else $error("tck half period too short");
  shift_len_a: assert property
    ($fell(shift) |-> rise_cnt_reg == CHAIN_LEN)
    else $error("shift burst not 33 tcks");
  ctl_excl_a: assert property
    ($onehot0({capture, shift, update, step, resume}))
    else $error("chain control lines overlap");
  sel_stable_a: assert property (shift |-> $stable(chain_sel))
    else $error("chain select moved during shift");
  cap_hold_a: assert property ($rose(capture) |-> cap_stand)
    else $error("capture pulse too short");
  sync_req_a: assert property
    (status[3:2] == TRANS_IDLE |-> status[ST_SYS_MODE])
    else $error("bus request outside system speed");
  dbg_idle_a: assert property
    (!status[ST_SYS_MODE] |-> status[3:2] == TRANS_DONE)
    else $error("transfer active at debug speed");
  done_back_a: assert property
    ($fell(status[ST_SYS_MODE]) |->
     status[ST_ACK] && status[3:2] == TRANS_DONE)
    else $error("left system speed without completion");
endmodule

// [tb_top.sv]
`timescale 1ns/1ns
module tb_top;
  import dcs_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_seen = 1'b0;
  logic        debug_entry = 1'b0;
  logic        entry_watchpoint = 1'b0;
  logic        entry_compressed = 1'b0;
  logic [31:0] core_data_out = 32'h0;
  logic        bus_grant = 1'b0;
  logic [31:0] rdata, core_instr, d, instr, e, m;
  logic        busy, core_step, sys_en, dbg_en, ack, tdo_q, tck_d = 1'b0;
  logic [1:0]  trans_type;
  logic [4:0]  core_mode, mode;
  logic [32:0] tdo_v = 33'h0, tdi_v = 33'h0;
  logic [31:0] exp_q[$], mask_q[$];
  int          seed, failures = 0, n_checks = 0, steps = 0, cyc = 0, n;
  always #10 clk = ~clk;
  dcs_if dbg_bus();
  dcs_device dcs_device_inst (.clk(clk), .reset(reset), .dbg(dbg_bus),
    .debug_entry(debug_entry), .entry_watchpoint(entry_watchpoint),
    .entry_compressed(entry_compressed), .core_data_out(core_data_out),
    .bus_grant(bus_grant), .core_instr(core_instr), .core_step(core_step),
    .system_clock_enable(sys_en), .debug_clock_enable(dbg_en),
    .debug_acknowledge(ack), .trans_type(trans_type),
    .core_mode(core_mode), .test_data_out_q(tdo_q));
  dcs_debugger dcs_debugger_inst (.clk(clk), .reset(reset), .dbg(dbg_bus),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .busy(busy));
  dcs_chk_asserts dcs_chk_asserts_inst (.clk(clk), .reset(reset),
    .tck(dbg_bus.tck), .capture(dbg_bus.capture), .shift(dbg_bus.shift),
    .update(dbg_bus.update), .select_chain(dbg_bus.select_chain),
    .chain_sel(dbg_bus.chain_sel), .resume(dbg_bus.resume),
    .step(dbg_bus.step), .status_rd(dbg_bus.status_rd),
    .mode_wr(dbg_bus.mode_wr), .test_data_input(dbg_bus.test_data_input),
    .test_data_output(dbg_bus.test_data_output), .status(dbg_bus.status));
  task automatic chk(input logic [32:0] got, input logic [32:0] want);
    n_checks++;
    if (got !== want) begin
      failures++;
      $display("[FAIL] %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // a gap cycle after each strobe keeps one assignment per time step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] v,
                        input logic [31:0] msk);
    exp_q.push_back(v);
    mask_q.push_back(msk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cmd(input logic [3:0] op);
    wr_reg(ADDR_CMD, {28'h0, op});
    // busy read at this edge still shows the value before the write
    @(posedge clk);
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n == 3000) begin
      failures++;
      give_verdict();
    end
    // device lags the debugger by its input synchronisers
    repeat (4) @(posedge clk);
  endtask
  task automatic load(input logic [31:0] v, input logic spd);
    wr_reg(ADDR_SPEED, {31'h0, spd});
    wr_reg(ADDR_WDATA, v);
    cmd(OP_CAPTURE);
    cmd(OP_SHIFT);
    cmd(OP_UPDATE);
  endtask
  task automatic sel(input logic [3:0] c);
    wr_reg(ADDR_WDATA, {28'h0, c});
    cmd(OP_SELECT);
  endtask
  always @(posedge clk) begin
    if (rd_seen) begin
      e = exp_q.pop_front();
      m = mask_q.pop_front();
      chk({1'b0, rdata & m}, {1'b0, e & m});
    end
    rd_seen <= rd;
  end
  // wire bits as the device sees them at each tck rise while shift is high, first bit lowest
  always @(posedge clk) begin
    tck_d <= dbg_bus.tck;
    if (dbg_bus.tck && !tck_d && dbg_bus.shift) begin
      tdo_v <= {dbg_bus.test_data_output, tdo_v[32:1]};
      tdi_v <= {dbg_bus.test_data_input, tdi_v[32:1]};
    end
    if (core_step === 1'b1)
      steps++;
    cyc++;
    if (cyc == 40000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    seed = 93;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    cmd(OP_STATUS);
    rd_reg(ADDR_STATUS, 32'h0000000D, 32'hFFFFFFFF);
    rd_reg(8'h14, 32'h0, 32'hFFFFFFFF);
    chk({ack, dbg_en, sys_en, trans_type}, 33'h1B);
    $display("test reset done");
    d = $random(seed);
    instr = $random(seed);
    core_data_out <= d;
    entry_watchpoint <= 1'b1;
    entry_compressed <= 1'b1;
    debug_entry <= 1'b1;
    @(posedge clk);
    debug_entry <= 1'b0;
    @(posedge clk);
    sel(4'h1);
    load(instr, 1'b0);
    chk(tdo_v, {1'b1, d});
    chk(tdi_v, {1'b0, instr});
    rd_reg(ADDR_RDATA, d, 32'hFFFFFFFF);
    cmd(OP_STEP);
    chk({1'b0, core_instr}, {1'b0, instr});
    chk(steps, 1);
    cmd(OP_STATUS);
    rd_reg(ADDR_STATUS, 32'h10, 32'h10);
    $display("test entry and chain done");
    mode = 5'($random(seed));
    load({27'h0, mode}, 1'b0);
    chk(tdo_v[32], 0);
    cmd(OP_MODE);
    chk(core_mode, mode);
    sel(4'h2);
    load(~instr, 1'b0);
    chk(tdo_v, 33'h0);
    chk(tdo_q, 1'b0);
    cmd(OP_STEP);
    chk(steps, 1);
    chk(core_instr === ~instr, 0);
    $display("test mode and refused chain done");
    sel(4'h1);
    load($random(seed), 1'b1);
    cmd(OP_STEP);
    load($random(seed), 1'b0);
    cmd(OP_STEP);
    wr_reg(ADDR_CMD, {28'h0, OP_RESUME});
    repeat (200) @(posedge clk);
    chk({ack, dbg_en, sys_en, trans_type}, 33'h4);
    bus_grant <= 1'b1;
    n = 0;
    while (sys_en !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk({ack, dbg_en, trans_type}, 33'hF);
    repeat (20) @(posedge clk);
    cmd(OP_STATUS);
    rd_reg(ADDR_STATUS, 32'h0D, 32'h2D);
    load(instr, 1'b0);
    chk(tdo_v[32], 1);
    $display("test system speed done");
    give_verdict();
  end
endmodule
